// [rtl/pcs_pkg.sv]
// Constants for the primary command and status configuration registers.
// Assumes byte offsets within a 256-byte configuration space.
package pcs_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] PCS_CMD_OFFSET = 8'h04;
  localparam logic [7:0] PCS_STS_OFFSET = 8'h06;
  localparam logic [5:0] PCS_CMD_DWORD = 6'h01;

  // ----------------------------------------------------------------------
  // Command register fields
  // ----------------------------------------------------------------------
  localparam int PCS_CMD_IO = 0;
  localparam int PCS_CMD_MEM = 1;
  localparam int PCS_CMD_MASTER = 2;
  localparam int PCS_CMD_SPECIAL = 3;
  localparam int PCS_CMD_WR_INVAL = 4;
  localparam int PCS_CMD_PALETTE = 5;
  localparam int PCS_CMD_PERR_RESP = 6;
  localparam int PCS_CMD_WAIT = 7;
  localparam int PCS_CMD_SERR = 8;
  localparam int PCS_CMD_BACK2BACK = 9;
  localparam logic [15:0] PCS_CMD_RESET = 16'h0000;
  localparam logic [15:0] PCS_CMD_WR_MASK = 16'h0147;

  // ----------------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------------
  localparam int PCS_STS_BACK2BACK = 7;
  localparam int PCS_STS_DATA_PAR = 8;
  localparam int PCS_STS_SIG_TABORT = 11;
  localparam int PCS_STS_RX_TABORT = 12;
  localparam int PCS_STS_RX_MABORT = 13;
  localparam int PCS_STS_SIG_SERR = 14;
  localparam int PCS_STS_DET_PAR = 15;
  localparam logic [15:0] PCS_STS_RESET = 16'h0020;
  localparam logic [15:0] PCS_STS_W1C_MASK = 16'hF900;

endpackage : pcs_pkg

// [rtl/pcs_cmd_reg.sv]
// Command register storage with hardwired read-only bits.
// Assumes write strobe and byte enables are on the clk_i domain.
`timescale 1ns/100ps
`default_nettype none

module pcs_cmd_reg
  import pcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_be_i,
  input wire logic [15:0] wr_data_i,
  output logic [15:0] cmd_o
);

  logic [15:0] cmd_r;
  logic [15:0] cmd_nxt;
  logic [15:0] lane_mask;

  // Only the writable bits follow a write; the rest stay zero.
  always_comb begin
    lane_mask = {{8{wr_be_i[1]}}, {8{wr_be_i[0]}}} & PCS_CMD_WR_MASK;
    cmd_nxt = cmd_r;
    if (wr_en_i) begin
      cmd_nxt = (cmd_r & ~lane_mask) | (wr_data_i & lane_mask); // [R2]
    end
    cmd_nxt = cmd_nxt & PCS_CMD_WR_MASK; // [R1] [R3] [R16]
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_r <= PCS_CMD_RESET;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  assign cmd_o = cmd_r;

endmodule : pcs_cmd_reg

`default_nettype wire

// [rtl/pcs_sts_reg.sv]
// Status register of sticky flags cleared by writing one.
// Assumes set and clear vectors are on the clk_i domain.
`timescale 1ns/100ps
`default_nettype none

module pcs_sts_reg
  import pcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [15:0] set_i,
  input wire logic [15:0] clr_i,
  output logic [15:0] sts_o
);

  logic [15:0] sts_r;
  logic [15:0] sts_nxt;

  // Each flag bit: a set in the same cycle as a clear wins.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      if (PCS_STS_W1C_MASK[gi]) begin : g_w1c
        always_comb begin
          sts_nxt[gi] = set_i[gi] | (sts_r[gi] & ~clr_i[gi]); // [R8]
        end
      end else begin : g_fixed
        always_comb begin
          sts_nxt[gi] = sts_r[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sts_r <= PCS_STS_RESET;
    end else begin
      sts_r <= sts_nxt;
    end
  end

  assign sts_o = sts_r;

endmodule : pcs_sts_reg

`default_nettype wire

// [rtl/pcs_regs.sv]
// Primary command and status configuration registers of a bridge.
// Assumes single-cycle configuration strobes and event pulses on clk_i.
//
// Summary of operation
// [R1] Back-to-back enable command bit reads zero and ignores writes.
// [R2] System error enable bit is read-write and gates system error cycles.
// [R3] Wait, palette, write-invalidate and special cycle bits read zero.
// [R4] Parity errors are reported only while parity response bit is one.
// [R5] Master enable gates acceptance of PCI cycles toward the hub side.
// [R6] Hub memory transactions are claimed only with memory space enable.
// [R7] Hub I/O transactions are claimed only with I/O space enable.
// [R8] Writing one clears a status flag; writing zero leaves it alone.
// [R9] Any hub parity error sets detected parity error, regardless of enable.
// [R10] Issuing a system error cycle sets the signaled system error flag.
// [R11] A master abort on own hub transaction sets received master abort.
// [R12] A target abort received as master sets received target abort.
// [R13] Ending a hub transaction with target abort sets signaled target abort.
// [R14] Initiator parity error sets data parity flag only with response on.
// [R15] Back-to-back capable status bit reads zero.
// [R16] Reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none

module pcs_regs
  import pcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  input wire logic hub_parity_err_i,
  input wire logic init_parity_err_i,
  input wire logic serr_request_i,
  input wire logic master_abort_i,
  input wire logic target_abort_rx_i,
  input wire logic target_abort_tx_i,
  input wire logic hub_mem_req_i,
  input wire logic hub_io_req_i,
  input wire logic pci_req_i,
  output logic serr_cycle_o,
  output logic parity_report_o,
  output logic hub_mem_claim_o,
  output logic hub_io_claim_o,
  output logic pci_accept_o,
  output logic master_enable_o,
  output logic memory_space_enable_o,
  output logic io_space_enable_o
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic dword_hit(input logic [7:0] addr);
    dword_hit = (addr[7:2] == PCS_CMD_DWORD);
  endfunction : dword_hit

  logic wr_hit;
  logic rd_hit;
  logic [15:0] cmd_w;
  logic [15:0] sts_w;
  logic [15:0] sts_set;
  logic [15:0] sts_clr;
  logic serr_fire;

  always_comb begin
    wr_hit = cfg_wr_i & dword_hit(cfg_addr_i);
    rd_hit = cfg_rd_i & dword_hit(cfg_addr_i);
  end

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  pcs_cmd_reg u_cmd (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr_en_i(wr_hit),
    .wr_be_i(cfg_be_i[1:0]),
    .wr_data_i(cfg_wdata_i[15:0]),
    .cmd_o(cmd_w)
  );

  // Hardware events feed the sticky flags; software clears by writing one.
  always_comb begin
    serr_fire = serr_request_i & cmd_w[PCS_CMD_SERR]; // [R2]
    sts_set = 16'h0000;
    sts_set[PCS_STS_DET_PAR] = hub_parity_err_i; // [R9]
    sts_set[PCS_STS_SIG_SERR] = serr_fire; // [R10]
    sts_set[PCS_STS_RX_MABORT] = master_abort_i; // [R11]
    sts_set[PCS_STS_RX_TABORT] = target_abort_rx_i; // [R12]
    sts_set[PCS_STS_SIG_TABORT] = target_abort_tx_i; // [R13]
    sts_set[PCS_STS_DATA_PAR] = init_parity_err_i
      & cmd_w[PCS_CMD_PERR_RESP]; // [R14]
    sts_clr = {16{wr_hit}} & {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}}
      & cfg_wdata_i[31:16] & PCS_STS_W1C_MASK; // [R8]
  end

  pcs_sts_reg u_sts (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .set_i(sts_set),
    .clr_i(sts_clr),
    .sts_o(sts_w)
  );

  // ----------------------------------------------------------------------
  // Read path and transaction gating
  // ----------------------------------------------------------------------
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ack_r;
  logic ack_nxt;
  logic serr_r;
  logic serr_nxt;
  logic perr_rep_r;
  logic perr_rep_nxt;
  logic mem_claim_r;
  logic mem_claim_nxt;
  logic io_claim_r;
  logic io_claim_nxt;
  logic pci_acc_r;
  logic pci_acc_nxt;
  logic [2:0] en_r;
  logic [2:0] en_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_hit) begin
      // Reserved and hardwired bits are masked to zero on the way out.
      rdata_nxt = {sts_w & PCS_STS_W1C_MASK,
                   cmd_w & PCS_CMD_WR_MASK}; // [R15] [R16]
    end
    ack_nxt = cfg_rd_i | cfg_wr_i;
    serr_nxt = serr_fire; // [R2]
    perr_rep_nxt = (hub_parity_err_i | init_parity_err_i)
      & cmd_w[PCS_CMD_PERR_RESP]; // [R4]
    mem_claim_nxt = hub_mem_req_i & cmd_w[PCS_CMD_MEM]; // [R6]
    io_claim_nxt = hub_io_req_i & cmd_w[PCS_CMD_IO]; // [R7]
    pci_acc_nxt = pci_req_i & cmd_w[PCS_CMD_MASTER]; // [R5]
    en_nxt = {cmd_w[PCS_CMD_MASTER], cmd_w[PCS_CMD_MEM], cmd_w[PCS_CMD_IO]};
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      serr_r <= 1'b0;
      perr_rep_r <= 1'b0;
      mem_claim_r <= 1'b0;
      io_claim_r <= 1'b0;
      pci_acc_r <= 1'b0;
      en_r <= 3'h0;
    end else begin
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      serr_r <= serr_nxt;
      perr_rep_r <= perr_rep_nxt;
      mem_claim_r <= mem_claim_nxt;
      io_claim_r <= io_claim_nxt;
      pci_acc_r <= pci_acc_nxt;
      en_r <= en_nxt;
    end
  end

  assign cfg_rdata_o = rdata_r;
  assign cfg_ack_o = ack_r;
  assign serr_cycle_o = serr_r;
  assign parity_report_o = perr_rep_r;
  assign hub_mem_claim_o = mem_claim_r;
  assign hub_io_claim_o = io_claim_r;
  assign pci_accept_o = pci_acc_r;
  assign master_enable_o = en_r[2];
  assign memory_space_enable_o = en_r[1];
  assign io_space_enable_o = en_r[0];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  chk_cmd_b2b_zero: assert property ( // [R1]
    cfg_ack_o |-> !cfg_rdata_o[PCS_CMD_BACK2BACK])
    else $error("back-to-back enable read as one");

  chk_serr_gate: assert property ( // [R2]
    serr_request_i |=> (serr_cycle_o == $past(cmd_w[PCS_CMD_SERR])))
    else $error("system error cycle not gated by its enable");

  chk_hardwired_zero: assert property ( // [R3]
    (cfg_rdata_o[7:3] & 5'h17) == 5'h00)
    else $error("hardwired command bit read as one");

  chk_parity_report: assert property ( // [R4]
    (hub_parity_err_i && !cmd_w[PCS_CMD_PERR_RESP]
     && !init_parity_err_i) |=> !parity_report_o)
    else $error("parity error reported while response disabled");

  chk_parity_report_on: assert property ( // [R4]
    (hub_parity_err_i && cmd_w[PCS_CMD_PERR_RESP]) |=> parity_report_o)
    else $error("parity error not reported while response enabled");

  chk_pci_accept: assert property ( // [R5]
    pci_req_i ##1 pci_accept_o |-> $past(cmd_w[PCS_CMD_MASTER]))
    else $error("PCI cycle accepted with master enable off");

  chk_mem_claim: assert property ( // [R6]
    (hub_mem_req_i && cmd_w[PCS_CMD_MEM]) ##1 1'b1 |-> hub_mem_claim_o)
    else $error("memory transaction not claimed while enabled");

  chk_io_claim: assert property ( // [R7]
    !(hub_io_req_i && cmd_w[PCS_CMD_IO]) |=> !hub_io_claim_o)
    else $error("I/O claim without an enabled request");

  chk_io_claim_on: assert property ( // [R7]
    (hub_io_req_i && cmd_w[PCS_CMD_IO]) |=> hub_io_claim_o)
    else $error("I/O transaction not claimed while enabled");

  chk_mem_claim_off: assert property ( // [R6]
    !(hub_mem_req_i && cmd_w[PCS_CMD_MEM]) |=> !hub_mem_claim_o)
    else $error("memory claim without an enabled request");

  chk_pci_accept_on: assert property ( // [R5]
    (pci_req_i && cmd_w[PCS_CMD_MASTER]) |=> pci_accept_o)
    else $error("PCI cycle refused with master enable on");

  chk_serr_write: assert property ( // [R2]
    (wr_hit && cfg_be_i[1])
    |=> (cmd_w[PCS_CMD_SERR] == $past(cfg_wdata_i[PCS_CMD_SERR])))
    else $error("system error enable did not follow its write");

  chk_clear_flag: assert property ( // [R8]
    (wr_hit && cfg_be_i[3] && cfg_wdata_i[31] && !hub_parity_err_i)
    |=> !sts_w[PCS_STS_DET_PAR])
    else $error("write of one did not clear detected parity error");

  chk_flag_hold: assert property ( // [R8]
    (sts_w[PCS_STS_RX_MABORT]
     && !(wr_hit && cfg_be_i[3] && cfg_wdata_i[29]))
    |=> sts_w[PCS_STS_RX_MABORT])
    else $error("status flag lost without a write of one");

  chk_set_wins: assert property ( // [R9]
    hub_parity_err_i |=> sts_w[PCS_STS_DET_PAR])
    else $error("detected parity error flag not set");

  chk_serr_flag_set: assert property ( // [R10]
    (serr_request_i && cmd_w[PCS_CMD_SERR])
    |=> sts_w[PCS_STS_SIG_SERR])
    else $error("signaled system error flag not set");

  chk_serr_flag_gate: assert property ( // [R10]
    (!sts_w[PCS_STS_SIG_SERR]
     && !(serr_request_i && cmd_w[PCS_CMD_SERR]))
    |=> !sts_w[PCS_STS_SIG_SERR])
    else $error("system error flag set without a system error cycle");

  chk_abort_flags: assert property ( // [R11]
    master_abort_i |=> sts_w[PCS_STS_RX_MABORT])
    else $error("received master abort flag not set");

  chk_rx_tabort_set: assert property ( // [R12]
    target_abort_rx_i |=> sts_w[PCS_STS_RX_TABORT])
    else $error("received target abort flag not set");

  chk_sig_tabort_set: assert property ( // [R13]
    target_abort_tx_i |=> sts_w[PCS_STS_SIG_TABORT])
    else $error("signaled target abort flag not set");

  chk_data_par_gate: assert property ( // [R14]
    (!sts_w[PCS_STS_DATA_PAR] && !(init_parity_err_i
     && cmd_w[PCS_CMD_PERR_RESP])) |=> !sts_w[PCS_STS_DATA_PAR])
    else $error("data parity flag set without enabled cause");

  chk_data_par_set: assert property ( // [R14]
    (init_parity_err_i && cmd_w[PCS_CMD_PERR_RESP])
    |=> sts_w[PCS_STS_DATA_PAR])
    else $error("data parity flag not set while response enabled");

  chk_sts_reserved: assert property ( // [R15]
    cfg_ack_o |-> (cfg_rdata_o[26:16] & 11'h6FF) == 11'h000)
    else $error("status reserved or hardwired bit read as one");

  chk_sts_b2b_zero: assert property ( // [R15]
    cfg_ack_o |-> !cfg_rdata_o[16 + PCS_STS_BACK2BACK])
    else $error("back-to-back capable status bit read as one");

  chk_cmd_reserved: assert property ( // [R16]
    cfg_rdata_o[15:10] == 6'h00)
    else $error("command reserved bits read as one");

  chk_unmapped_zero: assert property ( // [R16]
    (cfg_rd_i && !rd_hit) |=> (cfg_rdata_o == 32'h0000_0000))
    else $error("unmapped read returned a nonzero value");

  cov_clear_flag: cover property (
    sts_w[PCS_STS_SIG_SERR] ##1 (wr_hit && cfg_wdata_i[30])
    ##1 !sts_w[PCS_STS_SIG_SERR]);
  cov_set_clear: cover property (
    wr_hit && cfg_be_i[3] && cfg_wdata_i[31] && hub_parity_err_i);
  cov_serr_fired: cover property (serr_cycle_o);
  cov_claims: cover property (hub_mem_claim_o ##1 hub_io_claim_o);
  cov_data_par_set: cover property (
    init_parity_err_i && cmd_w[PCS_CMD_PERR_RESP]);

endmodule : pcs_regs

`default_nettype wire

// [dv/pcs_hub_model.sv]
// Hub-side partner: presents requests, parity errors and aborts.
// Assumes the bench changes the event vector at falling clock edges.
`timescale 1ns/100ps
`default_nettype none

module pcs_hub_model (
  input wire logic reset_i,
  input wire logic [8:0] ev_i,
  output logic [8:0] ev_o
);
  // Nothing reaches the device while it is held in reset.
  always_comb begin
    ev_o = reset_i ? 9'h000 : ev_i;
  end
endmodule : pcs_hub_model

`default_nettype wire

// [dv/pcs_regs_tb.sv]
// Self-checking bench for the primary command and status registers.
// Assumes pcs_pkg is compiled first and the hub model passes events on.
`timescale 1ns/100ps
`default_nettype none

module pcs_regs_tb
  import pcs_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata;
  logic cfg_ack;
  logic [8:0] ev_cmd = 9'h000;
  logic [8:0] ev;
  logic [4:0] gated;
  logic [2:0] en;
  logic [15:0] cmd_m = 16'h0000;
  logic [15:0] sts_m = 16'h0000;
  logic [31:0] rd;
  logic [8:0] v;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 32'h261C;

  always #12.5 clk_i = ~clk_i;

  pcs_hub_model u_pcs_hub_model (.reset_i(reset_i), .ev_i(ev_cmd),
    .ev_o(ev));

  pcs_regs u_pcs_regs (.clk_i(clk_i), .reset_i(reset_i),
    .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr),
    .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata),
    .cfg_ack_o(cfg_ack), .hub_parity_err_i(ev[0]),
    .init_parity_err_i(ev[1]), .serr_request_i(ev[2]),
    .master_abort_i(ev[3]), .target_abort_rx_i(ev[4]),
    .target_abort_tx_i(ev[5]), .hub_mem_req_i(ev[6]),
    .hub_io_req_i(ev[7]), .pci_req_i(ev[8]), .serr_cycle_o(gated[4]),
    .parity_report_o(gated[3]), .hub_mem_claim_o(gated[2]),
    .hub_io_claim_o(gated[1]), .pci_accept_o(gated[0]),
    .master_enable_o(en[2]), .memory_space_enable_o(en[1]),
    .io_space_enable_o(en[0]));

  // --------------------------------------------------------------------
  // Expectations
  // --------------------------------------------------------------------
  function automatic logic [4:0] exp_gated(input logic [8:0] e);
    return {e[2] & cmd_m[8], (e[0] | e[1]) & cmd_m[6], e[6] & cmd_m[1],
      e[7] & cmd_m[0], e[8] & cmd_m[2]};
  endfunction : exp_gated

  function automatic logic [15:0] exp_set(input logic [8:0] e);
    logic [15:0] s;
    s = 16'h0000;
    s[PCS_STS_DET_PAR] = e[0];
    s[PCS_STS_SIG_SERR] = e[2] & cmd_m[PCS_CMD_SERR];
    s[PCS_STS_RX_MABORT] = e[3];
    s[PCS_STS_RX_TABORT] = e[4];
    s[PCS_STS_SIG_TABORT] = e[5];
    s[PCS_STS_DATA_PAR] = e[1] & cmd_m[PCS_CMD_PERR_RESP];
    return s;
  endfunction : exp_set

  // --------------------------------------------------------------------
  // Driver tasks
  // --------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] got,
    input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic cfg(input logic wr, input logic [7:0] a,
    input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_i);
    cfg_wr = wr;
    cfg_rd = ~wr;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge clk_i);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    rd = cfg_rdata;
    check("ack", {31'h0, cfg_ack}, 32'h1);
    if (wr && a[7:2] == 6'h01) begin
      for (int i = 0; i < 2; i++) begin
        if (be[i]) cmd_m[8*i+:8] = d[8*i+:8] & PCS_CMD_WR_MASK[8*i+:8];
        if (be[i+2]) sts_m[8*i+:8] &= ~(d[16+8*i+:8] &
          PCS_STS_W1C_MASK[8*i+:8]);
      end
    end
  endtask : cfg

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 4'h0, 32'h0);
    check("read", rd, exp);
  endtask : rdchk

  task automatic pulse(input logic [8:0] e);
    @(negedge clk_i);
    ev_cmd = e;
    @(negedge clk_i);
    ev_cmd = 9'h000;
    check("gated", {27'h0, gated}, {27'h0, exp_gated(e)});
    sts_m = sts_m | exp_set(e);
  endtask : pulse

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    rdchk(8'h04, 32'h0);
    $display("test reset done");
    cfg(1'b1, 8'h04, 4'hF, 32'hFFFF_FFFF);
    rdchk(8'h04, {sts_m, cmd_m});
    cfg(1'b1, 8'h08, 4'hF, 32'hFFFF_FFFF);
    rdchk(8'h08, 32'h0);
    rdchk(8'h04, {sts_m, cmd_m});
    $display("test map done");
    pulse(9'h1FF);
    rdchk(8'h04, {sts_m, cmd_m});
    cfg(1'b1, 8'h04, 4'hC, 32'h0000_0000);
    rdchk(8'h04, {sts_m, cmd_m});
    cfg(1'b1, 8'h04, 4'h8, 32'hFFFF_0000);
    rdchk(8'h04, {sts_m, cmd_m});
    // A parity error in the same cycle as its clearing write must win.
    fork
      cfg(1'b1, 8'h04, 4'h8, 32'h8000_0000);
      pulse(9'h001);
    join
    sts_m[PCS_STS_DET_PAR] = 1'b1;
    rdchk(8'h04, {sts_m, cmd_m});
    $display("test flags done");
    repeat (60) begin
      cfg(1'b1, 8'h04, 4'($random(seed)), 32'($random(seed)));
      rdchk(8'h04, {sts_m, cmd_m});
      check("enables", {29'h0, en}, {29'h0, cmd_m[2:0]});
      repeat (2) begin
        v = 9'($random(seed));
        v[0] = v[0] | v[1];
        pulse(v);
      end
      rdchk(8'h04, {sts_m, cmd_m});
    end
    $display("test random done");
    end_of_test();
  end
endmodule : pcs_regs_tb

`default_nettype wire
